// file: gate_driver_fault_config_regs.sv
`timescale 1ns/1ns
`include "gd_regs_params.svh"
module gate_driver_fault_config_regs (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rst_n,
   // Register access port
   input  wire logic                regWrite,
   input  wire logic                regRead,
   input  wire gd_regs_pkg::addr_t  regAddr,
   input  wire gd_regs_pkg::word_t  regWdata,
   output gd_regs_pkg::word_t       regRdata,
   output logic                     regRvalid,
   output logic                     nvmProgram,
   // Fault event inputs, asynchronous to clk
   input  wire logic [7:0]          analogEvents,
   input  wire logic [7:0]          digitalEvents,
   // Duty measurements
   input  wire logic [11:0]         dutyA,
   input  wire logic [11:0]         dutyB,
   // Analog configuration outputs
   output logic                     correctionBypass,
   output logic                     pinVerify,
   output logic [7:0]               gainTrim,
   output logic [7:0]               offsetTrim,
   output logic [7:0]               negRailLockoutOff,
   output logic                     shortCmdPriorityEn,
   output logic                     satSelftestObserveEn,
   output logic                     gateSenseSatOff,
   output logic                     tempFilterOff,
   output logic [1:0]               tempThresholdSel,
   output logic                     tempBiasOff,
   output logic [2:0]               satBlankSel,
   output logic [2:0]               supplyThresholdSel,
   output logic                     turnOnEdgeSel,
   output logic                     turnOffEdgeSel,
   // Secondary fault pin, low while asserted
   input  wire logic                selftestCompOut,
   output logic                     secondaryFaultPin_n
);
   // ----------------------------------------
   // Event synchronisers, three stages
   // ----------------------------------------
   logic [7:0] anaS1_q, anaS2_q, anaS3_q;
   logic [7:0] digS1_q, digS2_q, digS3_q;
   logic       cmpS1_q, cmpS2_q, cmpS3_q;

   // Second and third stages must agree before an event counts
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         anaS1_q <= 8'h00;
         anaS2_q <= 8'h00;
         anaS3_q <= 8'h00;
         digS1_q <= 8'h00;
         digS2_q <= 8'h00;
         digS3_q <= 8'h00;
         cmpS1_q <= 1'b0;
         cmpS2_q <= 1'b0;
         cmpS3_q <= 1'b0;
      end else begin
         anaS1_q <= analogEvents;
         anaS2_q <= anaS1_q;
         anaS3_q <= anaS2_q;
         digS1_q <= digitalEvents;
         digS2_q <= digS1_q;
         digS3_q <= digS2_q;
         cmpS1_q <= selftestCompOut;
         cmpS2_q <= cmpS1_q;
         cmpS3_q <= cmpS2_q;
      end
   end

   logic [7:0] anaEvt;
   logic [7:0] digEvt;
   assign anaEvt = anaS2_q & anaS3_q;
   assign digEvt = digS2_q & digS3_q;

   // ----------------------------------------
   // Write qualification
   // ----------------------------------------
   logic [7:0] ctrl_q;
   logic       simOk;
   logic       wrAny;
   logic       wrOk;
   // Control register itself must stay writable to arm the simulate bits
   assign simOk = &ctrl_q[`CTRL_SIM_LSB +: 2];
   assign wrAny = regWrite && (regAddr == `ADDR_NVM_CTRL);
   assign wrOk  = regWrite && simOk;
   // Masks are full register width; only the low byte is kept, on purpose
   logic [14:0] digClrWord;
   logic [14:0] ctrlWord;
   assign digClrWord = regWdata & `MASK_DIG_RW;
   assign ctrlWord   = regWdata & `MASK_CTRL;

   // ----------------------------------------
   // Sticky fault banks
   // ----------------------------------------
   fault_bus_if anaBus ();
   fault_bus_if digBus ();

   // Digital flags write-one-to-clear; user ECC flags are read-only so never cleared
   assign anaBus.events = anaEvt;
   assign anaBus.clear  = 8'h00;
   assign digBus.events = digEvt;
   assign digBus.clear  = (regWrite && regAddr == `ADDR_SEC_DIGITAL)
                          ? digClrWord[7:0] : 8'h00;

   fault_latch_bank uAnalog (
      .clk   (clk),
      .rst_n (rst_n),
      .fb    (anaBus)
   );
   fault_latch_bank uDigital (
      .clk   (clk),
      .rst_n (rst_n),
      .fb    (digBus)
   );

   // Analog flags clear when their cause goes away, held as read-only
   logic [7:0] anaView;
   assign anaView = anaBus.flags & anaEvt;

   // ----------------------------------------
   // Control register, always writable
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_q <= 8'h00;
      end else if (wrAny) begin
         ctrl_q <= ctrlWord[7:0];
      end
   end

   // Program pulse when simulate and program are all set on a control write while both simulate bits are already set
   logic nvmProgram_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         nvmProgram_q <= 1'b0;
      end else begin
         nvmProgram_q <= wrAny && (&regWdata[1:0]) && regWdata[`CTRL_PROGRAM]
                         && simOk;
      end
   end

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   logic [7:0] gain_q, offset_q, negOff_q, cfgA_q;
   logic [6:0] cfgB_q;
   logic [1:0] cfgC_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         gain_q   <= 8'h00;
         offset_q <= 8'h00;
         negOff_q <= 8'h00;
         cfgA_q   <= 8'h00;
         cfgB_q   <= 7'h00;
         cfgC_q   <= 2'h0;
      end else if (wrOk) begin
         case (regAddr)
            `ADDR_GAIN_TRIM:    gain_q   <= regWdata[7:0];
            `ADDR_OFFSET_TRIM:  offset_q <= regWdata[7:0];
            `ADDR_NEG_LOCK_OFF: negOff_q <= regWdata[7:0];
            `ADDR_CFG_A:        cfgA_q   <= regWdata[7:0];
            `ADDR_CFG_B:        cfgB_q   <= regWdata[6:0];
            `ADDR_CFG_C:        cfgC_q   <= regWdata[1:0];
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------
   // Outputs to the analog side
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         correctionBypass     <= 1'b0;
         pinVerify            <= 1'b0;
         gainTrim             <= 8'h00;
         offsetTrim           <= 8'h00;
         negRailLockoutOff    <= 8'h00;
         shortCmdPriorityEn   <= 1'b0;
         satSelftestObserveEn <= 1'b0;
         gateSenseSatOff      <= 1'b0;
         tempFilterOff        <= 1'b0;
         tempThresholdSel     <= 2'h0;
         tempBiasOff          <= 1'b0;
         satBlankSel          <= 3'h0;
         supplyThresholdSel   <= 3'h0;
         turnOnEdgeSel        <= 1'b0;
         turnOffEdgeSel       <= 1'b0;
         nvmProgram           <= 1'b0;
      end else begin
         correctionBypass     <= ctrl_q[`CTRL_CORR_BYPASS];
         pinVerify            <= ctrl_q[`CTRL_PIN_VERIFY];
         gainTrim             <= gain_q;
         offsetTrim           <= offset_q;
         negRailLockoutOff    <= negOff_q;
         shortCmdPriorityEn   <= cfgA_q[6];
         satSelftestObserveEn <= cfgA_q[5];
         gateSenseSatOff      <= cfgA_q[4];
         tempFilterOff        <= cfgA_q[3];
         tempThresholdSel     <= cfgA_q[2:1];
         tempBiasOff          <= cfgA_q[0];
         satBlankSel          <= cfgB_q[5:3];
         supplyThresholdSel   <= cfgB_q[2:0];
         turnOnEdgeSel        <= cfgC_q[1];
         turnOffEdgeSel       <= cfgC_q[0];
         nvmProgram           <= nvmProgram_q;
      end
   end

   // ----------------------------------------
   // Secondary fault pin
   // ----------------------------------------
   // Self-test observation overrides the CRC route while enabled
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         secondaryFaultPin_n <= 1'b1;
      end else if (cfgA_q[5]) begin
         // Follow the comparator only once two stages agree; hold otherwise
         if (cmpS2_q == cmpS3_q) begin
            secondaryFaultPin_n <= ~cmpS3_q;
         end
      end else begin
         secondaryFaultPin_n <= ~(cfgB_q[6] && digBus.flags[1]);
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   gd_regs_pkg::word_t rdMux;
   always_comb begin
      rdMux = `RESET_ZERO;
      case (regAddr)
         `ADDR_DUTY_A:       rdMux = {3'h0, dutyA};
         `ADDR_DUTY_B:       rdMux = {3'h0, dutyB};
         `ADDR_PRI_ID:       rdMux = {7'h00, `PRI_ID_VALUE};
         `ADDR_SEC_ANALOG:   rdMux = {7'h00, anaView};
         `ADDR_SEC_DIGITAL:  rdMux = {7'h00, digBus.flags};
         `ADDR_NVM_CTRL:     rdMux = {7'h00, ctrl_q};
         `ADDR_GAIN_TRIM:    rdMux = {7'h00, gain_q};
         `ADDR_OFFSET_TRIM:  rdMux = {7'h00, offset_q};
         `ADDR_NEG_LOCK_OFF: rdMux = {7'h00, negOff_q};
         `ADDR_CFG_A:        rdMux = {7'h00, cfgA_q};
         `ADDR_CFG_B:        rdMux = {8'h00, cfgB_q};
         `ADDR_CFG_C:        rdMux = {13'h0000, cfgC_q};
         `ADDR_SEC_ID:       rdMux = {7'h00, `SEC_ID_VALUE};
         default:            rdMux = `RESET_ZERO;
      endcase
   end

   // Read data registered one cycle after the strobe
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         regRdata  <= `RESET_ZERO;
         regRvalid <= 1'b0;
      end else begin
         regRvalid <= regRead;
         if (regRead) begin
            regRdata <= rdMux;
         end
      end
   end
endmodule : gate_driver_fault_config_regs

// file: gd_regs_params.svh
// Summary of operation
// - Gate mismatch flags in secondary analog bits 7,6
// - Secondary overtemperature flag in analog bit 4
// - Negative rail overvolt bit 3, undervolt bit 2
// - Positive supply overvolt bit 1, undervolt bit 0
// - User ECC uncorrectable bit 7, corrected bit 6
// - Factory ECC uncorrectable bit 5, corrected bit 4
// - Self test bit 2, CRC bit 1, link bit 0
// - Duty readbacks are 12-bit read-only values
// - Negative rail lockout disable field bits 7:0
// - Config A bit 6 gives short command priority
// - Config A bit 5 shows saturation self-test on pin
// - Config A bit 4 disables gate-sense saturation control
// - Config A bit 3 bypasses temperature filter
// - Config A bits 2:1 select temperature threshold
// - Config A bit 0 switches off temperature bias
// - Config B bit 6 routes CRC fault to pin
// - Config B bits 5:3 select blanking time
// - Config B bits 2:0 select supply threshold
// - Writing one clears a latched digital fault bit 5:0
// - Config writes need both simulate bits; program needs all
`ifndef GD_REGS_PARAMS_SVH
`define GD_REGS_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_DUTY_A        7'h08
`define ADDR_DUTY_B        7'h09
`define ADDR_PRI_ID        7'h3F
`define ADDR_SEC_ANALOG    7'h40
`define ADDR_SEC_DIGITAL   7'h41
`define ADDR_NVM_CTRL      7'h42
`define ADDR_GAIN_TRIM     7'h50
`define ADDR_OFFSET_TRIM   7'h51
`define ADDR_NEG_LOCK_OFF  7'h52
`define ADDR_CFG_A         7'h53
`define ADDR_CFG_B         7'h54
`define ADDR_CFG_C         7'h55
`define ADDR_SEC_ID        7'h7F

// ----------------------------------------
// Field masks and positions
// ----------------------------------------
`define REG_W              15
`define MASK_BYTE          15'h00FF
`define MASK_DUTY          15'h0FFF
`define MASK_CTRL          15'h00C7
`define MASK_CFG_B         15'h007F
`define MASK_CFG_C         15'h0003
`define MASK_DIG_RW        15'h003F
`define CTRL_SIM_LSB       0
`define CTRL_PROGRAM       2
`define CTRL_CORR_BYPASS   6
`define CTRL_PIN_VERIFY    7
`define RESET_ZERO         15'h0000
`define PRI_ID_VALUE       8'h5A
`define SEC_ID_VALUE       8'hA5

`endif

// file: gd_regs_pkg.sv
package gd_regs_pkg;
   typedef logic [14:0] word_t;
   typedef logic [6:0]  addr_t;
endpackage : gd_regs_pkg

// file: fault_bus_if.sv
`timescale 1ns/1ns
// Fault events and clears passed between top and the latch bank
interface fault_bus_if;
   logic [7:0] events;
   logic [7:0] clear;
   logic [7:0] flags;
   modport owner (output events, output clear, input flags);
   modport bank  (input events, input clear, output flags);
endinterface : fault_bus_if

// file: fault_latch_bank.sv
`timescale 1ns/1ns
module fault_latch_bank (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fault traffic
   fault_bus_if.bank fb
);
   logic [7:0] flags_q;

   // ----------------------------------------
   // Sticky flags; a new event beats a clear in the same cycle
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flags_q <= 8'h00;
      end else begin
         flags_q <= (flags_q & ~fb.clear) | fb.events;
      end
   end

   assign fb.flags = flags_q;
endmodule : fault_latch_bank

// file: fault_source_model.sv
`timescale 1ns/1ns
// ---------------------------------------
// Far-side sensor model
// ---------------------------------------
module fault_source_model (
   // Clock
   input  wire logic       clk,
   // Requested fault levels
   input  wire logic [7:0] anaReq,
   input  wire logic [7:0] digReq,
   // Event levels toward the block
   output logic [7:0]      analogEvents,
   output logic [7:0]      digitalEvents
);
   // Comparators switch off the edge, so the block must synchronise them
   always @(posedge clk) begin
      analogEvents <= #1 anaReq;
      digitalEvents <= #1 digReq;
   end
endmodule : fault_source_model

// file: gd_regs_assertions.sv
`timescale 1ns/1ns
`include "gd_regs_params.svh"
module gd_regs_assertions (
   // Clock and reset
   input wire logic               clk,
   input wire logic               rst_n,
   // Register port
   input wire logic               regWrite,
   input wire logic               regRead,
   input wire gd_regs_pkg::addr_t regAddr,
   input wire gd_regs_pkg::word_t regWdata,
   input wire gd_regs_pkg::word_t regRdata,
   input wire logic               regRvalid,
   input wire logic               nvmProgram,
   // Duty and configuration
   input wire logic [11:0]        dutyA,
   input wire logic               shortCmdPriorityEn,
   input wire logic [1:0]         tempThresholdSel,
   input wire logic [2:0]         satBlankSel,
   input wire logic [2:0]         supplyThresholdSel
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic simOk_q;
   // Mirror of the simulate pair; only a control write moves it
   always_ff @(posedge clk) begin
      if (!rst_n) simOk_q <= 1'b0;
      else if (regWrite && regAddr == `ADDR_NVM_CTRL) simOk_q <= (regWdata[1:0] == 2'h3);
   end
   // ---------------------------------------
   // Sequences and properties
   // ---------------------------------------
   sequence s_wrA; regWrite && simOk_q && regAddr == `ADDR_CFG_A; endsequence
   sequence s_wrB; regWrite && simOk_q && regAddr == `ADDR_CFG_B; endsequence
   property p_answer; regRead |=> regRvalid; endproperty
   property p_quiet; !regRead |=> !regRvalid; endproperty
   property p_cfgA; s_wrA |-> ##2 shortCmdPriorityEn == $past(regWdata[6], 2)
      && tempThresholdSel == $past(regWdata[2:1], 2); endproperty
   property p_lockA; regWrite && !simOk_q && regAddr == `ADDR_CFG_A
      |-> ##2 $stable(shortCmdPriorityEn); endproperty
   property p_cfgB; s_wrB |-> ##2 satBlankSel == $past(regWdata[5:3], 2)
      && supplyThresholdSel == $past(regWdata[2:0], 2); endproperty
   property p_program; regWrite && simOk_q && regAddr == `ADDR_NVM_CTRL
      && regWdata[2:0] == 3'h7 |-> ##2 nvmProgram; endproperty
   property p_secId; regRead && regAddr == `ADDR_SEC_ID
      |=> regRdata == {7'h00, `SEC_ID_VALUE}; endproperty
   property p_unmapped; regRead && regAddr == 7'h10 |=> regRdata == 15'h0000; endproperty
   property p_duty; regRead && regAddr == `ADDR_DUTY_A
      |=> regRdata == {3'h0, $past(dutyA)}; endproperty
   property p_reserved; regRvalid |-> regRdata[14:12] == 3'h0; endproperty
   a_answer: assert property (p_answer) else $error("read not answered");
   a_quiet: assert property (p_quiet) else $error("spurious read valid");
   a_cfgA: assert property (p_cfgA) else $error("config a not applied");
   a_lockA: assert property (p_lockA) else $error("locked write applied");
   a_cfgB: assert property (p_cfgB) else $error("config b not applied");
   a_program: assert property (p_program) else $error("program missing");
   a_secId: assert property (p_secId) else $error("identity wrong");
   a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
   a_duty: assert property (p_duty) else $error("duty readback wrong");
   a_reserved: assert property (p_reserved) else $error("reserved bits set");
endmodule : gd_regs_assertions

// file: gate_driver_fault_config_regs_bench.sv
`timescale 1ns/1ns
`include "gd_regs_params.svh"
module gate_driver_fault_config_regs_bench;
   logic               clk = 1'b0;
   logic               rst_n = 1'b0;
   logic               regWrite = 1'b0;
   logic               regRead = 1'b0;
   logic               selftestCompOut = 1'b0;
   gd_regs_pkg::addr_t regAddr = 7'h00;
   gd_regs_pkg::word_t regWdata = 15'h0000;
   gd_regs_pkg::word_t regRdata;
   logic [7:0]         anaReq = 8'h00;
   logic [7:0]         digReq = 8'h00;
   logic [11:0]        dutyA = 12'hABC;
   logic [11:0]        dutyB = 12'h123;
   logic [7:0]         analogEvents, digitalEvents, negRailLockoutOff, gainTrim, offsetTrim;
   logic               correctionBypass, pinVerify, satSelftestObserveEn;
   logic               gateSenseSatOff, tempFilterOff;
   logic               regRvalid, nvmProgram, secondaryFaultPin_n, tempBiasOff;
   logic               shortCmdPriorityEn, turnOnEdgeSel, turnOffEdgeSel;
   logic [1:0]         tempThresholdSel;
   logic [2:0]         satBlankSel, supplyThresholdSel;
   int                 failures = 0;
   int                 cmpCount = 0;
   gd_regs_pkg::addr_t cfgAddr [6] = '{7'h50, 7'h51, 7'h52, 7'h53, 7'h54, 7'h55};
   gd_regs_pkg::word_t cfgMask [6] = '{15'h00FF, 15'h00FF, 15'h00FF, 15'h00FF, 15'h007F, 15'h0003};
   // Free-running 100 MHz clock
   always #5 clk = ~clk;
   fault_source_model sensors (.clk, .anaReq, .digReq, .analogEvents, .digitalEvents);
   gate_driver_fault_config_regs uut (.clk, .rst_n, .regWrite, .regRead, .regAddr, .regWdata,
      .regRdata, .regRvalid, .nvmProgram, .analogEvents, .digitalEvents, .dutyA, .dutyB,
      .correctionBypass, .pinVerify, .gainTrim, .offsetTrim, .negRailLockoutOff,
      .shortCmdPriorityEn, .satSelftestObserveEn, .gateSenseSatOff, .tempFilterOff,
      .tempThresholdSel, .tempBiasOff, .satBlankSel, .supplyThresholdSel, .turnOnEdgeSel,
      .turnOffEdgeSel, .selftestCompOut, .secondaryFaultPin_n);
   // ---------------------------------------
   // Access tasks, all entered 1 ns after an edge
   // ---------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic chk(input string what, input gd_regs_pkg::word_t seen,
                      input gd_regs_pkg::word_t exp);
      cmpCount++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic results();
      $display("comparisons %0d failures %0d", cmpCount, failures);
      if (failures == 0 && cmpCount > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : results
   // Idle cycle after each write keeps strobes from being re-driven in one step
   task automatic wr(input gd_regs_pkg::addr_t a, input gd_regs_pkg::word_t d);
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      tick(1);
      regWrite = 1'b0;
      tick(1);
   endtask : wr
   task automatic rd(input gd_regs_pkg::addr_t a, input gd_regs_pkg::word_t exp,
                     input string what);
      regAddr = a;
      regRead = 1'b1;
      tick(1);
      regRead = 1'b0;
      // Valid stands only in the cycle after the strobe edge, so look now
      repeat (3) if (regRvalid !== 1'b1) tick(1);
      if (regRvalid !== 1'b1) begin
         failures++;
         results();
      end
      chk(what, regRdata, exp);
      tick(1);
   endtask : rd
   // Main sequence
   initial begin
      tick(3);
      rst_n = 1'b1;
      tick(1);
      rd(`ADDR_CFG_B, 15'h0000, "cfg b reset");
      wr(`ADDR_CFG_A, 15'h0040);
      rd(`ADDR_CFG_A, 15'h0000, "locked cfg a");
      wr(`ADDR_NVM_CTRL, 15'h7FC3);
      chk("no program", {14'h0000, nvmProgram}, 15'h0000);
      rd(`ADDR_NVM_CTRL, 15'h00C3, "control");
      foreach (cfgAddr[i]) begin
         wr(cfgAddr[i], 15'h7FFF);
         rd(cfgAddr[i], cfgMask[i], "config mask");
      end
      wr(`ADDR_CFG_A, 15'h0055);
      wr(`ADDR_CFG_B, 15'h001A);
      wr(`ADDR_CFG_C, 15'h0002);
      wr(`ADDR_NEG_LOCK_OFF, 15'h00A5);
      chk("cfg fields", {3'h0, shortCmdPriorityEn, tempThresholdSel, tempBiasOff, satBlankSel,
          supplyThresholdSel, turnOnEdgeSel, turnOffEdgeSel}, 15'h0D6A);
      chk("lockout off", {7'h00, negRailLockoutOff}, 15'h00A5);
      chk("trims", {gainTrim[6:0], offsetTrim}, 15'h7FFF);
      chk("cfg a bits", {10'h000, correctionBypass, pinVerify, satSelftestObserveEn,
          gateSenseSatOff, tempFilterOff}, 15'h001A);
      rd(`ADDR_PRI_ID, {7'h00, `PRI_ID_VALUE}, "primary id");
      rd(`ADDR_SEC_ID, {7'h00, `SEC_ID_VALUE}, "secondary id");
      rd(7'h10, 15'h0000, "unmapped");
      wr(`ADDR_DUTY_A, 15'h7FFF);
      rd(`ADDR_DUTY_A, 15'h0ABC, "duty a");
      rd(`ADDR_DUTY_B, 15'h0123, "duty b");
      digReq = 8'hF2;
      tick(2);
      digReq = 8'h00;
      tick(5);
      rd(`ADDR_SEC_DIGITAL, 15'h00F2, "digital flags");
      wr(`ADDR_CFG_B, 15'h005A);
      tick(2);
      chk("pin routed", {14'h0000, secondaryFaultPin_n}, 15'h0000);
      wr(`ADDR_SEC_DIGITAL, 15'h0012);
      rd(`ADDR_SEC_DIGITAL, 15'h00E0, "partial clear");
      tick(2);
      chk("pin released", {14'h0000, secondaryFaultPin_n}, 15'h0001);
      wr(`ADDR_SEC_DIGITAL, 15'h7FFF);
      rd(`ADDR_SEC_DIGITAL, 15'h00C0, "ro ecc flags");
      anaReq = 8'h9F;
      tick(5);
      rd(`ADDR_SEC_ANALOG, 15'h009F, "analog flags");
      anaReq = 8'h00;
      tick(5);
      rd(`ADDR_SEC_ANALOG, 15'h0000, "analog idle");
      wr(`ADDR_NVM_CTRL, 15'h0007);
      chk("program pulse", {14'h0000, nvmProgram}, 15'h0001);
      selftestCompOut = 1'b1;
      wr(`ADDR_CFG_A, 15'h0020);
      tick(3);
      chk("selftest on pin", {14'h0000, secondaryFaultPin_n}, 15'h0000);
      // Mid-run reset must bring config and pin back to their idle values
      selftestCompOut = 1'b0;
      rst_n = 1'b0;
      tick(3);
      rst_n = 1'b1;
      tick(1);
      rd(`ADDR_CFG_A, 15'h0000, "cfg a after reset");
      chk("pin after reset", {14'h0000, secondaryFaultPin_n}, 15'h0001);
      results();
   end
endmodule : gate_driver_fault_config_regs_bench
bind gate_driver_fault_config_regs gd_regs_assertions checks (.clk, .rst_n, .regWrite,
   .regRead, .regAddr, .regWdata, .regRdata, .regRvalid, .nvmProgram, .dutyA,
   .shortCmdPriorityEn, .tempThresholdSel, .satBlankSel, .supplyThresholdSel);
